// ### hdl/lcd_bleeder_bank.sv
// apb register bank for bleeder control and segment buffers 0 and 1
`timescale 1ns/1ps
// Operation
// [R1] connect time code 000 never connects, 110 always connects, 111 is reserved.
// [R2] codes 001-101 connect for 2^(10+code-base) system clocks or about 2^(code+1)/2^code low-speed periods.
// [R3] source bit 3 chooses external (0) or internal (1) bleeder resistance.
// [R4] connect timing and high value select only act while the internal source is chosen.
// [R5] buffer 0 holds segment 1 in bits 7-4 and segment 0 in bits 3-0.
// [R6] buffer 1 holds segment 3 in bits 7-4 and segment 2 in bits 3-0.
// [R7] unused bits read zero and ignore writes; nibble msb is common phase 3, lsb phase 0.
// [R8] base field divides system clock by 2^18..2^14 or low-speed clock by 2^9, 2^8; others reserved.
// [R9] with the enable cleared other registers are not clocked and keep their contents.
module lcd_bleeder_bank (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // low-speed clock from outside the domain
    input  wire logic        low_speed_clk_i,
    // panel side
    output logic             frame_tick_o,
    output logic             internal_bleeder_o,
    output logic             high_bleeder_value_o,
    output logic             low_bleeder_connect_o,
    output logic [15:0]      segment_data_o
);
    logic                    module_enable_q;
    logic [3:0]              base_frequency_select_q;
    logic [2:0]              duty_q;
    logic                    display_on_q;
    lcd_bank_pkg::bleeder_cfg_t bleeder_q;
    logic [7:0]              segment_buffer_0_q;
    logic [7:0]              segment_buffer_1_q;
    logic [1:0]              ls_sync_q;
    logic                    ls_prev_q;
    logic [lcd_bank_pkg::CNT_W-1:0] div_q;
    logic                    tick_q;
    logic                    timer_active;

    // apb decode
    wire access     = psel_i && penable_i;
    wire hit_en     = paddr_i == lcd_bank_pkg::ADDR_ENABLE;
    wire hit_cr1    = paddr_i == lcd_bank_pkg::ADDR_CONTROL1;
    wire hit_bl     = paddr_i == lcd_bank_pkg::ADDR_BLEEDER;
    wire hit_b0     = paddr_i == lcd_bank_pkg::ADDR_SEGBUF0;
    wire hit_b1     = paddr_i == lcd_bank_pkg::ADDR_SEGBUF1;
    wire mapped     = hit_en || hit_cr1 || hit_bl || hit_b0 || hit_b1;
    // one wait state: answer the cycle after the access phase starts
    wire answer     = access && !pready_o;
    wire rd_answer  = answer && !pwrite_i;
    // writes land only at the completing edge, as the master sees them
    wire wr         = access && pwrite_i && mapped && pready_o;
    // gated registers: writes only land while the module clock runs
    wire wr_gated   = wr && module_enable_q; // [R9]

    wire ls_rise    = ls_sync_q[1] && !ls_prev_q;
    // base codes 0101-0111 and 1010 up are reserved and give no ticks
    wire base_sys   = base_frequency_select_q <= lcd_bank_pkg::BASE_SYS_MAX;
    wire base_ls    = base_frequency_select_q == lcd_bank_pkg::BASE_LS_SLOW
                   || base_frequency_select_q == lcd_bank_pkg::BASE_LS_FAST;

    function automatic logic [lcd_bank_pkg::CNT_W-1:0] pow2(input int e);
        pow2 = lcd_bank_pkg::CNT_W'(1) << e;
    endfunction : pow2

    // divider length per base code
    wire [lcd_bank_pkg::CNT_W-1:0] frame_len = base_sys
        ? pow2(lcd_bank_pkg::SYS_DIV_TOP_EXP - int'(base_frequency_select_q))
        : (base_frequency_select_q == lcd_bank_pkg::BASE_LS_SLOW
            ? pow2(lcd_bank_pkg::LS_DIV_SLOW_EXP)
            : pow2(lcd_bank_pkg::LS_DIV_FAST_EXP)); // [R8]
    wire div_step   = base_sys || (base_ls && ls_rise);
    wire div_wrap   = div_step && div_q >= frame_len - 1'b1;

    // connect length in timer steps: core cycles on system bases, synchronised
    // low-speed edges on low-speed bases; the low-speed time runs up to one
    // core cycle short, since each tick trails its low-speed edge
    wire [2:0] code = bleeder_q.connect_time;
    wire [lcd_bank_pkg::CNT_W-1:0] conn_len = base_sys
        ? pow2(lcd_bank_pkg::SYS_CONN_EXP + int'(code) - int'(base_frequency_select_q))
        : (base_frequency_select_q == lcd_bank_pkg::BASE_LS_SLOW
            ? pow2(int'(code) + 1) : pow2(int'(code))); // [R2]
    wire timed_code = code != lcd_bank_pkg::LCT_NEVER && code < lcd_bank_pkg::LCT_ALWAYS;
    wire run_timer  = module_enable_q && bleeder_q.internal_src && timed_code
                   && (base_sys || base_ls); // [R4]
    // reserved code 111 falls through to disconnected
    wire conn_next  = bleeder_q.internal_src && module_enable_q
                   && (code == lcd_bank_pkg::LCT_ALWAYS || (timed_code && timer_active)); // [R1] [R4]

    // unmapped offsets read as zero and flag an error
    wire [31:0] rd_mux =
          hit_en  ? {31'h0000_0000, module_enable_q}
        : hit_cr1 ? {24'h00_0000, display_on_q, duty_q, base_frequency_select_q}
        : hit_bl  ? {24'h00_0000, bleeder_q.connect_time, bleeder_q.high_value,
                     bleeder_q.internal_src, 3'h0} // [R7]
        : hit_b0  ? {24'h00_0000, segment_buffer_0_q}
        : hit_b1  ? {24'h00_0000, segment_buffer_1_q}
        : lcd_bank_pkg::RESET_WORD;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            module_enable_q <= 1'b0;
        else if (wr && hit_en)
            module_enable_q <= pwdata_i[0];
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            base_frequency_select_q <= 4'h0;
            duty_q                  <= 3'h0;
            display_on_q            <= 1'b0;
            bleeder_q               <= '0;
            segment_buffer_0_q      <= 8'h00;
            segment_buffer_1_q      <= 8'h00;
        end
        else if (wr_gated)
        begin
            if (hit_cr1)
            begin
                base_frequency_select_q <= pwdata_i[3:0];
                duty_q                  <= pwdata_i[6:4];
                display_on_q            <= pwdata_i[7];
            end
            if (hit_bl)
            begin
                bleeder_q.connect_time <= pwdata_i[lcd_bank_pkg::LCT_LSB +: 3]; // [R1]
                bleeder_q.high_value   <= pwdata_i[lcd_bank_pkg::HBV_BIT];
                bleeder_q.internal_src <= pwdata_i[lcd_bank_pkg::SRC_BIT]; // [R3]
            end
            if (hit_b0)
                segment_buffer_0_q <= pwdata_i[7:0]; // [R5] [R7]
            if (hit_b1)
                segment_buffer_1_q <= pwdata_i[7:0]; // [R6] [R7]
        end
    end

    // low-speed clock sampled through two flops before use
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ls_sync_q <= 2'b00;
            ls_prev_q <= 1'b0;
        end
        else
        begin
            ls_sync_q <= {ls_sync_q[0], low_speed_clk_i};
            ls_prev_q <= ls_sync_q[1];
        end
    end

    // reserved base codes stop the divider
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= module_enable_q && div_wrap; // [R8]
            if (!module_enable_q || !(base_sys || base_ls))
                div_q <= '0;
            else if (div_wrap)
                div_q <= '0;
            else if (div_step)
                div_q <= div_q + 1'b1;
        end
    end

    bleeder_timer #(
        .CNT_W (lcd_bank_pkg::CNT_W)
    ) u_timer (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .run_i      (run_timer),
        .start_i    (tick_q),
        .step_i     (div_step),
        .length_i   (conn_len),
        .active_o   (timer_active)
    );

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prdata_o              <= lcd_bank_pkg::RESET_WORD;
            pready_o              <= 1'b0;
            pslverr_o             <= 1'b0;
            frame_tick_o          <= 1'b0;
            internal_bleeder_o    <= 1'b0;
            high_bleeder_value_o  <= 1'b0;
            low_bleeder_connect_o <= 1'b0;
            segment_data_o        <= 16'h0000;
        end
        else
        begin
            pready_o              <= answer;
            pslverr_o             <= answer && !mapped;
            prdata_o              <= rd_answer ? rd_mux : lcd_bank_pkg::RESET_WORD; // [R7]
            frame_tick_o          <= tick_q;
            internal_bleeder_o    <= bleeder_q.internal_src; // [R3]
            high_bleeder_value_o  <= bleeder_q.internal_src && bleeder_q.high_value; // [R4]
            low_bleeder_connect_o <= conn_next; // [R1]
            segment_data_o        <= {segment_buffer_1_q, segment_buffer_0_q}; // [R5] [R6]
        end
    end
endmodule : lcd_bleeder_bank

// ### hdl/lcd_bank_pkg.sv
// register map, field layout and timing constants of the bleeder and segment bank
package lcd_bank_pkg;
    localparam logic [11:0] ADDR_ENABLE     = 12'h000;
    localparam logic [11:0] ADDR_CONTROL1   = 12'h004;
    localparam logic [11:0] ADDR_BLEEDER    = 12'h008;
    localparam logic [11:0] ADDR_SEGBUF0    = 12'h00C;
    localparam logic [11:0] ADDR_SEGBUF1    = 12'h010;
    localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
    localparam int          LCT_LSB         = 5;
    localparam int          HBV_BIT         = 4;
    localparam int          SRC_BIT         = 3;
    localparam int          SEG_HI_LSB      = 4;
    localparam int          SEG_LO_LSB      = 0;
    localparam logic [2:0]  LCT_NEVER       = 3'h0;
    localparam logic [2:0]  LCT_ALWAYS      = 3'h6;
    localparam logic [2:0]  LCT_RESERVED    = 3'h7;
    localparam logic [3:0]  BASE_SYS_MAX    = 4'h4;
    localparam logic [3:0]  BASE_LS_SLOW    = 4'h8;
    localparam logic [3:0]  BASE_LS_FAST    = 4'h9;
    localparam int          SYS_DIV_TOP_EXP = 18;
    localparam int          LS_DIV_SLOW_EXP = 9;
    localparam int          LS_DIV_FAST_EXP = 8;
    localparam int          SYS_CONN_EXP    = 10;
    localparam int          CNT_W           = 20;

    typedef struct packed {
        logic [2:0] connect_time;
        logic       high_value;
        logic       internal_src;
    } bleeder_cfg_t;

    typedef struct packed {
        logic [3:0] segment_three_data;
        logic [3:0] segment_two_data;
        logic [3:0] segment_one_data;
        logic [3:0] segment_zero_data;
    } seg_data_t;
endpackage : lcd_bank_pkg

// ### hdl/bleeder_timer.sv
// one-shot timer that holds the low bleeder connected after each frame tick
`timescale 1ns/1ps
module bleeder_timer #(
    parameter int CNT_W = 20
) (
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    // control
    input  wire logic             run_i,
    input  wire logic             start_i,
    input  wire logic             step_i,
    input  wire logic [CNT_W-1:0] length_i,
    // result
    output logic                  active_o
);
    logic [CNT_W-1:0] count_q;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            count_q <= '0;
        else if (!run_i)
            count_q <= '0;
        else if (start_i)
            count_q <= length_i;
        else if (step_i && count_q != '0)
            count_q <= count_q - 1'b1;
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            active_o <= 1'b0;
        else
            active_o <= run_i && (start_i || count_q > 1 || (count_q == 1 && !step_i));
    end
endmodule : bleeder_timer

// ### tb/lcd_bleeder_bank_assertions.sv
// port-level checks of the bleeder and segment bank
`timescale 1ns/1ps
module lcd_bleeder_bank_checker (
    // clock, reset and apb
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // low-speed clock and panel side
    input wire logic        low_speed_clk_i,
    input wire logic        frame_tick_o,
    input wire logic        internal_bleeder_o,
    input wire logic        high_bleeder_value_o,
    input wire logic        low_bleeder_connect_o,
    input wire logic [15:0] segment_data_o
);
    logic        en_q;
    logic [7:0]  bl_q;
    logic [15:0] seg_q;
    // shadow copies; writes land at the edge that completes the access
    wire         wr   = psel_i && penable_i && pwrite_i && pready_o;
    wire         wr_e = wr && en_q;
    wire [2:0]   code = bl_q[7:5];
    always_ff @(posedge core_clk_i or posedge rst_i)
        if (rst_i)
            {en_q, bl_q, seg_q} <= '0;
        else if (wr)
        begin
            if (paddr_i == lcd_bank_pkg::ADDR_ENABLE) en_q <= pwdata_i[0];
            if (wr_e && paddr_i == lcd_bank_pkg::ADDR_BLEEDER) bl_q <= pwdata_i[7:0];
            if (wr_e && paddr_i == lcd_bank_pkg::ADDR_SEGBUF0) seg_q[7:0] <= pwdata_i[7:0];
            if (wr_e && paddr_i == lcd_bank_pkg::ADDR_SEGBUF1) seg_q[15:8] <= pwdata_i[7:0];
        end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    a_code_never: assert property ((en_q && code == 3'h0)[*3] |-> !low_bleeder_connect_o)
        else $error("connected under code zero");
    a_code_always: assert property ((en_q && bl_q[3] && code == 3'h6)[*3] |->
        low_bleeder_connect_o) else $error("not connected under code six");
    a_source_follows: assert property ((en_q && $stable(bl_q))[*3] |->
        internal_bleeder_o == bl_q[3]) else $error("source output wrong");
    a_external_ignores: assert property ((en_q && !bl_q[3])[*3] |->
        !high_bleeder_value_o && !low_bleeder_connect_o) else $error("external not ignoring");
    a_segment_map: assert property ($stable(seg_q)[*3] |-> segment_data_o == seg_q)
        else $error("segment output wrong");
    a_unused_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h00_0000)
        else $error("unused read bits set");
    a_tick_pulse: assert property (frame_tick_o |=> !frame_tick_o [*8])
        else $error("frame tick too close");
    a_disabled_quiet: assert property ((!en_q)[*3] |-> !frame_tick_o && !low_bleeder_connect_o)
        else $error("activity while disabled");
endmodule : lcd_bleeder_bank_checker
bind lcd_bleeder_bank lcd_bleeder_bank_checker checker_inst (.core_clk_i, .rst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .low_speed_clk_i, .frame_tick_o, .internal_bleeder_o, .high_bleeder_value_o,
    .low_bleeder_connect_o, .segment_data_o);

// ### tb/lcd_panel_model.sv
// behavioural panel: counts frames, latches the pattern shown
`timescale 1ns/1ps
module lcd_panel_model (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // drive from the bank
    input  wire logic        frame_tick_i,
    input  wire logic [15:0] segment_data_i,
    // observed state
    output int               frames_o,
    output logic [15:0]      shown_o
);
    // glass refreshes once per frame, so take the pattern at the tick
    always_ff @(posedge core_clk_i or posedge rst_i)
        if (rst_i)
        begin
            frames_o <= 0;
            shown_o  <= 16'h0000;
        end
        else if (frame_tick_i)
        begin
            frames_o <= frames_o + 1;
            shown_o  <= segment_data_i;
        end
endmodule : lcd_panel_model

// ### tb/lcd_bleeder_and_segment_buffer_tb.sv
// self-checking bench for the bleeder and segment bank
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end
module lcd_bleeder_and_segment_buffer_tb;
    logic        core_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic        low_speed_clk_i = 0, pready_o, pslverr_o, frame_tick_o;
    logic        internal_bleeder_o, high_bleeder_value_o, low_bleeder_connect_o;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, d0, d1, rnd;
    logic [15:0] segment_data_o, shown;
    logic [33:0] exp_q[$];
    logic [33:0] ent;
    int          frames, miscompares = 0, tests_run = 0, cycles = 0, seed = 98;
    lcd_bleeder_bank lcd_bleeder_bank_inst (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .low_speed_clk_i, .frame_tick_o,
        .internal_bleeder_o, .high_bleeder_value_o, .low_bleeder_connect_o, .segment_data_o);
    lcd_panel_model lcd_panel_model_inst (.core_clk_i, .rst_i, .frame_tick_i(frame_tick_o),
        .segment_data_i(segment_data_o), .frames_o(frames), .shown_o(shown));
    initial forever #10 core_clk_i = ~core_clk_i;
    // offset by 5 ns so no low-speed edge meets a core edge
    initial #5 forever #50 low_speed_clk_i = ~low_speed_clk_i;
    task conclude;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic er);
        exp_q.push_back({w, er, e});
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : apb
    task automatic measure(input logic [3:0] base, input logic [2:0] code,
                           input int plo, input int phi, input int onlo, input int onhi);
        int p = 0;
        int c = 0;
        int w;
        apb(1, lcd_bank_pkg::ADDR_CONTROL1, {28'h000_0000, base}, 0, 0);
        apb(1, lcd_bank_pkg::ADDR_BLEEDER, {24'h00_0000, code, 5'h08}, 0, 0);
        w = frames;
        while (frames == w) @(posedge core_clk_i);
        w = frames;
        // one whole period holds exactly one pulse whatever the phase
        while (frames == w)
        begin
            @(posedge core_clk_i);
            p++;
            c += low_bleeder_connect_o;
        end
        `CHK("frame period", 1'b1, p >= plo && p <= phi)
        `CHK("connect time", 1'b1, c >= onlo && c <= onhi)
        `CHK("panel pattern", segment_data_o, shown)
    endtask : measure
    always @(posedge core_clk_i)
        if (pready_o === 1'b1)
        begin
            ent = exp_q.pop_front();
            if (!ent[33]) `CHK("read data", ent[31:0], prdata_o)
            `CHK("error flag", ent[32], pslverr_o)
        end
    always @(posedge core_clk_i)
        if (++cycles == 60000)
        begin
            miscompares++;
            conclude();
        end
    initial
    begin
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        for (int a = 0; a <= 16; a += 4) apb(0, a[11:0], 0, 0, 0);
        apb(1, lcd_bank_pkg::ADDR_SEGBUF0, 32'h0000_00FF, 0, 0);
        apb(0, lcd_bank_pkg::ADDR_SEGBUF0, 0, 0, 0);
        apb(1, lcd_bank_pkg::ADDR_ENABLE, 32'h0000_0001, 0, 0);
        repeat (4)
        begin
            d0 = $random(seed);
            d1 = $random(seed);
            apb(1, lcd_bank_pkg::ADDR_SEGBUF0, d0, 0, 0);
            apb(1, lcd_bank_pkg::ADDR_SEGBUF1, d1, 0, 0);
            apb(0, lcd_bank_pkg::ADDR_SEGBUF0, 0, {24'h00_0000, d0[7:0]}, 0);
            apb(0, lcd_bank_pkg::ADDR_SEGBUF1, 0, {24'h00_0000, d1[7:0]}, 0);
            `CHK("segment data", {d1[7:0], d0[7:0]}, segment_data_o)
        end
        apb(0, 12'h014, 0, 0, 1);
        apb(1, 12'hFFC, 32'hFFFF_FFFF, 0, 1);
        $display("done buffers and decode");
        for (int c = 0; c < 8; c++)
        begin
            rnd = $random(seed);
            apb(1, lcd_bank_pkg::ADDR_BLEEDER, {rnd[31:8], c[2:0], 2'b11, rnd[2:0]}, 0, 0);
            apb(0, lcd_bank_pkg::ADDR_BLEEDER, 0, {24'h00_0000, c[2:0], 5'h18}, 0);
            `CHK("source", 1'b1, internal_bleeder_o)
            `CHK("high value", 1'b1, high_bleeder_value_o)
            `CHK("connect", c == 6, low_bleeder_connect_o)
        end
        apb(1, lcd_bank_pkg::ADDR_BLEEDER, 32'h0000_00D0, 0, 0);
        repeat (2) @(posedge core_clk_i);
        `CHK("source", 1'b0, internal_bleeder_o)
        `CHK("ignored high", 1'b0, high_bleeder_value_o)
        `CHK("ignored connect", 1'b0, low_bleeder_connect_o)
        $display("done bleeder codes");
        measure(4'h4, 3'h1, 16384, 16384, 1 << (10 + 1 - 4), 1 << (10 + 1 - 4));
        // low-speed period is five core cycles here; the time is only rough
        measure(4'h9, 3'h2, 1278, 1282, (1 << 2) * 5 - 5, (1 << 2) * 5);
        $display("done timing");
        apb(1, lcd_bank_pkg::ADDR_ENABLE, 0, 0, 0);
        apb(1, lcd_bank_pkg::ADDR_SEGBUF1, 32'h0000_00AA, 0, 0);
        apb(0, lcd_bank_pkg::ADDR_SEGBUF1, 0, {24'h00_0000, d1[7:0]}, 0);
        apb(0, lcd_bank_pkg::ADDR_BLEEDER, 0, 32'h0000_0048, 0);
        `CHK("frozen segments", {d1[7:0], d0[7:0]}, segment_data_o)
        $display("done disable");
        conclude();
    end
endmodule : lcd_bleeder_and_segment_buffer_tb
